//--- hdl/tbp_parser.v
// Transmit buffer command parser with AXI4-Lite access
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`include "tbp_consts.vh"

// What this block does
// - Offset field sets skipped leading bytes
// - First and last segment flags delimit packets
// - Size and alignment give trailing pad DWORDs
// - Sum buffer sizes, error on mismatch
// - Packet tag copied into the TAG register and mac_tag
// - Second word bit 13 disables FCS unless bit 12 is set
// - Bit 12 disables padding, FCS kept
// - Supplied bytes differ from length: error
// - Two command words precede buffer data
// - Upper offset bits skip whole DWORDs
// - Alignment codes 4, 16, 32 bytes
// - Low offset bits select first lane
// - Differing second words raise error
// - Interrupt bit raises buffer-loaded flag
module tbp_parser (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Payload stream to the MAC
  output wire        mac_valid,
  input  wire        mac_ready,
  output wire [7:0]  mac_data,
  output wire        mac_last,
  // Per-packet controls to the MAC
  output reg         mac_no_fcs,
  output reg         mac_no_pad,
  output reg  [15:0] mac_tag,
  // Events
  output reg         transmit_error_flag,
  output reg         buffer_loaded_flag
);

  // ----------------------------------------------------------------
  // Parser states
  // ----------------------------------------------------------------
  localparam ST_CMDA = 3'h0;
  localparam ST_CMDB = 3'h1;
  localparam ST_SKIP = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_PAD  = 3'h4;

  function [4:0] pad_dwords;
    input [1:0]  align;
    input [10:0] size;
    input [1:0]  lane;
    reg   [12:0] used;
    reg   [2:0]  amask;
    begin
      used  = ({2'h0, size} + {11'h000, lane} + 13'h0003) >> 2;
      amask = (align == `TBP_ALIGN_16) ? 3'h3 : (align == `TBP_ALIGN_32) ? 3'h7 : 3'h0;
      pad_dwords = {2'h0, (~used[2:0] + 3'h1) & amask};
    end
  endfunction

  reg  [2:0]  state_r;
  reg  [31:0] cmda_r;
  reg  [31:0] pktb_r;
  reg         in_pkt_r;
  reg  [11:0] sum_r;
  reg  [2:0]  skip_r;
  reg  [4:0]  pad_r;
  reg  [10:0] left_r;
  reg  [31:0] word_r;
  reg  [1:0]  lane_r;
  reg         unpack_r;
  reg  [31:0] status_r;
  reg  [15:0] last_tag_r;
  reg         err_sticky_r;
  reg         done_sticky_r;
  reg  [7:0]  awaddr_r;
  reg         aw_have_r;
  reg  [31:0] wdata_r;
  reg         w_have_r;
  reg         fifo_stall;

  wire        buf_ready;
  // A first segment, or one after a finished packet, restarts the size sum
  wire [11:0] sum_nxt = (cmda_r[`TBP_A_FIRST] || !in_pkt_r) ? {1'b0, cmda_r[`TBP_SIZE_HI:0]} :
                        sum_r + {1'b0, cmda_r[`TBP_SIZE_HI:0]};
  wire        last_byte = (left_r == 11'h001);
  wire        at_dword_end = (lane_r == 2'h3) || last_byte;

  // ----------------------------------------------------------------
  // AXI4-Lite write path; data words to the FIFO register feed the parser
  // ----------------------------------------------------------------
  wire [7:0] aw_idx = {2'h0, awaddr_r[7:2]};
  wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid && !fifo_stall;
  wire word_in = wr_go && (aw_idx == `TBP_REG_FIFO >> 2);

  always @* begin
    fifo_stall = (aw_idx == `TBP_REG_FIFO >> 2) && unpack_r;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx == `TBP_REG_FIFO >> 2 ||
                         aw_idx == `TBP_REG_CTRL >> 2) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      case ({2'h0, s_axi_araddr[7:2]})
        `TBP_REG_STATUS >> 2: s_axi_rdata <= status_r;
        `TBP_REG_TAG >> 2:    s_axi_rdata <= {last_tag_r, 16'h0000};
        `TBP_REG_CTRL >> 2:   s_axi_rdata <= 32'h00000000;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Status: bit 0 error sticky, bit 1 buffer loaded sticky; write 1 to CTRL clears
  wire ctrl_wr = wr_go && (aw_idx == `TBP_REG_CTRL >> 2) && s_axi_wstrb[0];
  wire err_evt;
  wire done_evt;

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= `TBP_STATUS_RST;
    end else begin
      status_r <= {30'h0, done_sticky_r, err_sticky_r};
    end
  end

  // ----------------------------------------------------------------
  // Command parser and payload unpacker
  // ----------------------------------------------------------------
  wire byte_go = unpack_r && buf_ready;
  reg  [7:0] byte_sel;

  always @* begin
    case (lane_r)
      2'h0:    byte_sel = word_r[7:0];
      2'h1:    byte_sel = word_r[15:8];
      2'h2:    byte_sel = word_r[23:16];
      default: byte_sel = word_r[31:24];
    endcase
  end

  // Mismatch of declared and supplied bytes is caught at the last segment
  assign err_evt = (state_r == ST_CMDB && word_in &&
                    ((in_pkt_r && wdata_r != pktb_r) ||
                     (cmda_r[`TBP_A_ALIGN_HI:`TBP_A_ALIGN_LO] == `TBP_ALIGN_RSVD) ||
                     (cmda_r[`TBP_A_LAST] &&
                      sum_nxt != {1'b0, wdata_r[`TBP_SIZE_HI:0]})));
  assign done_evt = byte_go && last_byte && cmda_r[`TBP_A_IOC];

  always @(posedge aclk) begin
    if (!aresetn) begin
      err_sticky_r  <= 1'b0;
      done_sticky_r <= 1'b0;
      transmit_error_flag <= 1'b0;
      buffer_loaded_flag  <= 1'b0;
    end else begin
      transmit_error_flag <= err_evt;
      buffer_loaded_flag  <= done_evt;
      // Set wins over a clear in the same cycle
      err_sticky_r  <= err_evt  | (err_sticky_r  & ~(ctrl_wr & wdata_r[0]));
      done_sticky_r <= done_evt | (done_sticky_r & ~(ctrl_wr & wdata_r[1]));
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ST_CMDA;
      cmda_r     <= 32'h00000000;
      pktb_r     <= 32'h00000000;
      in_pkt_r   <= 1'b0;
      sum_r      <= 12'h000;
      skip_r     <= 3'h0;
      pad_r      <= 5'h00;
      left_r     <= 11'h000;
      word_r     <= 32'h00000000;
      lane_r     <= 2'h0;
      unpack_r   <= 1'b0;
      mac_no_fcs <= 1'b0;
      mac_no_pad <= 1'b0;
      mac_tag    <= 16'h0000;
      last_tag_r <= 16'h0000;
    end else begin
      if (byte_go) begin
        left_r <= left_r - 11'h001;
        lane_r <= lane_r + 2'h1;
        if (at_dword_end) begin
          unpack_r <= 1'b0;
        end
        if (last_byte) begin
          state_r <= (pad_r == 5'h00) ? ST_CMDA : ST_PAD;
        end
      end
      case (state_r)
        ST_CMDA: begin
          if (word_in) begin
            cmda_r  <= wdata_r;
            state_r <= ST_CMDB;
          end
        end
        ST_CMDB: begin
          if (word_in) begin
            if (cmda_r[`TBP_A_FIRST] || !in_pkt_r) begin
              pktb_r <= wdata_r;
              sum_r  <= {1'b0, cmda_r[`TBP_SIZE_HI:0]};
            end else begin
              sum_r  <= sum_nxt;
            end
            in_pkt_r   <= !cmda_r[`TBP_A_LAST];
            mac_tag    <= wdata_r[`TBP_B_TAG_HI:`TBP_B_TAG_LO];
            last_tag_r <= wdata_r[`TBP_B_TAG_HI:`TBP_B_TAG_LO];
            mac_no_fcs <= wdata_r[`TBP_B_NOCRC] & ~wdata_r[`TBP_B_NOPAD];
            mac_no_pad <= wdata_r[`TBP_B_NOPAD];
            skip_r  <= cmda_r[`TBP_A_OFS_HI:`TBP_A_OFS_LO + 2];
            lane_r  <= cmda_r[`TBP_A_OFS_LO + 1:`TBP_A_OFS_LO];
            left_r  <= cmda_r[`TBP_SIZE_HI:0];
            pad_r   <= pad_dwords(cmda_r[`TBP_A_ALIGN_HI:`TBP_A_ALIGN_LO],
                                  cmda_r[`TBP_SIZE_HI:0],
                                  cmda_r[`TBP_A_OFS_LO + 1:`TBP_A_OFS_LO]);
            if (cmda_r[`TBP_A_OFS_HI:`TBP_A_OFS_LO + 2] != 3'h0) begin
              state_r <= ST_SKIP;
            end else if (cmda_r[`TBP_SIZE_HI:0] != 11'h000) begin
              state_r <= ST_DATA;
            end else begin
              state_r <= ST_CMDA;
            end
          end
        end
        ST_SKIP: begin
          if (word_in) begin
            skip_r <= skip_r - 3'h1;
            if (skip_r == 3'h1) begin
              state_r <= (left_r != 11'h000) ? ST_DATA : ST_CMDA;
            end
          end
        end
        ST_DATA: begin
          if (word_in) begin
            word_r   <= wdata_r;
            unpack_r <= 1'b1;
          end
        end
        ST_PAD: begin
          if (word_in) begin
            pad_r <= pad_r - 5'h01;
            if (pad_r == 5'h01) begin
              state_r <= ST_CMDA;
            end
          end
        end
        default: state_r <= ST_CMDA;
      endcase
    end
  end

  // A new data word is held off by the FIFO-register stall while unpacking
  tbp_skid_buf u_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (unpack_r),
    .in_ready  (buf_ready),
    .in_data   (byte_sel),
    .in_last   (last_byte & cmda_r[`TBP_A_LAST]),
    .out_valid (mac_valid),
    .out_ready (mac_ready),
    .out_data  (mac_data),
    .out_last  (mac_last)
  );

endmodule

//--- hdl/tbp_consts.vh
// Constants for the transmit buffer command parser
`ifndef TBP_CONSTS_VH
`define TBP_CONSTS_VH

// ----------------------------------------------------------------
// Register map (byte offsets)
// ----------------------------------------------------------------
`define TBP_REG_FIFO      8'h00
`define TBP_REG_STATUS    8'h04
`define TBP_REG_TAG       8'h08
`define TBP_REG_CTRL      8'h0c

// ----------------------------------------------------------------
// First command word fields
// ----------------------------------------------------------------
`define TBP_A_IOC         31
`define TBP_A_ALIGN_HI    25
`define TBP_A_ALIGN_LO    24
`define TBP_A_OFS_HI      20
`define TBP_A_OFS_LO      16
`define TBP_A_FIRST       13
`define TBP_A_LAST        12
`define TBP_SIZE_HI       10

// ----------------------------------------------------------------
// Second command word fields
// ----------------------------------------------------------------
`define TBP_B_TAG_HI      31
`define TBP_B_TAG_LO      16
`define TBP_B_NOCRC       13
`define TBP_B_NOPAD       12

// ----------------------------------------------------------------
// Alignment codes, reset values and buffer depth
// ----------------------------------------------------------------
`define TBP_ALIGN_4       2'h0
`define TBP_ALIGN_16      2'h1
`define TBP_ALIGN_32      2'h2
`define TBP_ALIGN_RSVD    2'h3
`define TBP_STATUS_RST    32'h00000000
`define TBP_BUF_DEPTH     2

`endif

//--- hdl/tbp_skid_buf.v
// Two-entry valid/ready buffer for the payload byte stream
module tbp_skid_buf (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Filling side
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [7:0]  in_data,
  input  wire        in_last,
  // Draining side
  output reg         out_valid,
  input  wire        out_ready,
  output reg  [7:0]  out_data,
  output reg         out_last
);

  reg  [8:0] slot_r;
  reg        slot_full_r;

  // Ready depends only on the spare slot, so no combinational path back
  assign in_ready = ~slot_full_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      out_valid   <= 1'b0;
      out_data    <= 8'h00;
      out_last    <= 1'b0;
      slot_r      <= 9'h000;
      slot_full_r <= 1'b0;
    end else begin
      if (!out_valid || out_ready) begin
        if (slot_full_r) begin
          out_valid   <= 1'b1;
          {out_last, out_data} <= slot_r;
          slot_full_r <= 1'b0;
        end else begin
          out_valid <= in_valid;
          out_data  <= in_data;
          out_last  <= in_last;
        end
      end else if (in_valid && !slot_full_r) begin
        slot_r      <= {in_last, in_data};
        slot_full_r <= 1'b1;
      end
    end
  end

endmodule

//--- dv/tbp_parser_chk.sv
// Assertion checker for the transmit buffer command parser
module tbp_chk (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Register bus
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        s_axi_awready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  // Stream and events
  input logic        mac_valid,
  input logic        mac_ready,
  input logic [7:0]  mac_data,
  input logic        mac_last,
  input logic        mac_no_fcs,
  input logic        mac_no_pad,
  input logic        transmit_error_flag,
  input logic        buffer_loaded_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_MAC_HOLD: assert property (mac_valid && !mac_ready |=>
    mac_valid && $stable({mac_data, mac_last})) else $error("stalled byte changed");
  AST_ERR_PULSE: assert property (transmit_error_flag |=> !transmit_error_flag)
    else $error("error flag longer than one cycle");
  AST_LOADED_PULSE: assert property (buffer_loaded_flag |=> !buffer_loaded_flag)
    else $error("loaded flag longer than one cycle");
  AST_NOPAD_FCS: assert property (mac_no_pad |-> !mac_no_fcs)
    else $error("fcs dropped while padding disabled");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response not held");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    s_axi_rresp == (($past(s_axi_araddr) inside {8'h04, 8'h08, 8'h0c}) ? 2'h0 : 2'h2))
    else $error("read answer late or wrong code");
  AST_READY_BACK: assert property (s_axi_bvalid && s_axi_bready |-> ##[1:2] s_axi_awready)
    else $error("write address ready not restored");
endmodule

bind tbp_parser tbp_chk i_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .mac_valid, .mac_ready, .mac_data,
  .mac_last, .mac_no_fcs, .mac_no_pad, .transmit_error_flag, .buffer_loaded_flag);

//--- dv/tbp_host.sv
// Host model that writes transmit buffers over the register bus
module tbp_host (
  // Clock
  input  logic        aclk,
  // Write channels
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic [1:0]  s_axi_bresp,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  // Read channels
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  // Pad and skip words carry junk: the device must drop them
  task automatic send_buf(input logic ioc, input logic [1:0] al, input logic [4:0] ofs,
                          input logic f, input logic l, input logic [10:0] sz,
                          input logic [31:0] b, input logic [7:0] seed);
    int nd, tot, wd, p;
    logic [31:0] w;
    logic [1:0] r;
    // Alignment padding counts from lane 0 of the first data word; skip words lie before it
    nd = (ofs[1:0] + sz + 3) / 4;
    wd = (al == 2'h1) ? 4 : (al == 2'h2) ? 8 : 1;
    tot = ofs[4:2] + (nd + wd - 1) / wd * wd;
    wr(8'h00, {ioc, 5'h00, al, 3'h0, ofs, 2'h0, f, l, 1'h0, sz}, r);
    wr(8'h00, b, r);
    for (int k = 0; k < tot; k++) begin
      for (int j = 0; j < 4; j++) begin
        p = k * 4 + j - ofs;
        w[j*8 +: 8] = (p >= 0 && p < sz) ? seed + 8'(p) : 8'($urandom);
      end
      wr(8'h00, w, r);
    end
  endtask
endmodule

//--- dv/test_tx_buffer_command_parser.sv
// Self-checking bench for the transmit buffer command parser
module test_tx_buffer_command_parser;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 0, aresetn = 0, mac_ready = 0, stall = 0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, mac_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] mac_tag;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        mac_valid, mac_last, mac_no_fcs, mac_no_pad;
  logic        transmit_error_flag, buffer_loaded_flag;
  logic [8:0]  expq[$];
  int          errors = 0, samples_checked = 0, cycles = 0;
  int          err_cnt = 0, done_cnt = 0, err_base = 0, done_base = 0;

  always #5 aclk = ~aclk;
  always @(posedge aclk) mac_ready <= stall ? 1'b0 : (($urandom % 4) != 0);

  tbp_parser i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mac_valid, .mac_ready,
    .mac_data, .mac_last, .mac_no_fcs, .mac_no_pad, .mac_tag, .transmit_error_flag,
    .buffer_loaded_flag);
  tbp_host i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stream scoreboard
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    cycles++;
    if (transmit_error_flag)
      err_cnt++;
    if (buffer_loaded_flag)
      done_cnt++;
    if (cycles == 50000) begin
      errors++;
      give_verdict();
    end
    if (aresetn && mac_valid && mac_ready) begin
      if (expq.size() == 0)
        check("stray byte", 32'h0, 32'h1);
      else
        check("mac byte", expq.pop_front(), {mac_last, mac_data});
    end
  end

  task automatic pkt(input logic ioc, input logic [1:0] al, input logic [4:0] ofs,
                     input logic f, input logic l, input logic [10:0] sz,
                     input logic [31:0] b);
    logic [7:0] seed;
    seed = 8'($urandom);
    for (int p = 0; p < sz; p++) expq.push_back({l && p == sz - 1, seed + 8'(p)});
    i_host.send_buf(ioc, al, ofs, f, l, sz, b, seed);
  endtask

  // Drain the stream before reading, since status only settles after the last byte
  task automatic status(input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 3000 && expq.size() != 0; i++) @(posedge aclk);
    repeat (4) @(posedge aclk);
    i_host.rd(8'h04, d, r);
    check("status", exp, d);
    check("error pulses", exp[0], err_cnt - err_base);
    check("loaded pulses", exp[1], done_cnt - done_base);
    err_base = err_cnt;
    done_base = done_cnt;
    i_host.wr(8'h0c, 32'h3, r);
  endtask

  initial begin
    logic [31:0] d, b;
    logic [1:0]  r;
    logic [10:0] sz;
    void'($urandom(75862));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    i_host.rd(8'h04, d, r);
    check("status reset", 32'h0, d);
    i_host.rd(8'h20, d, r);
    check("unmapped read", 32'h2, r);
    i_host.wr(8'h20, 32'h0, r);
    check("unmapped write", 32'h2, r);
    $display("test register map done");
    for (int al = 0; al < 3; al++)
      for (int ln = 0; ln < 4; ln++) begin
        sz = 11'($urandom_range(40, 1));
        b = {16'($urandom), 2'h0, 2'($urandom), 1'h0, sz};
        pkt(ln[0], 2'(al), {3'($urandom), 2'(ln)}, 1, 1, sz, b);
        status({30'h0, ln[0], 1'b0});
        i_host.rd(8'h08, d, r);
        check("tag", b[31:16], d[31:16]);
        check("mac tag", b[31:16], mac_tag);
        check("no fcs", b[13] & ~b[12], mac_no_fcs);
        check("no pad", b[12], mac_no_pad);
      end
    $display("test single buffers done");
    b = {16'h0a5c, 5'h00, 11'h011};
    pkt(0, 2'h1, 5'h03, 1, 0, 11'h005, b);
    pkt(0, 2'h2, 5'h1e, 0, 0, 11'h009, b);
    pkt(0, 2'h0, 5'h01, 0, 1, 11'h003, b);
    status(32'h0);
    pkt(0, 2'h0, 5'h00, 1, 0, 11'h005, b);
    pkt(0, 2'h0, 5'h02, 0, 1, 11'h00d, b);
    status(32'h1);
    pkt(0, 2'h0, 5'h00, 1, 0, 11'h005, b);
    pkt(0, 2'h0, 5'h00, 0, 1, 11'h00c, b ^ 32'h00010000);
    status(32'h1);
    $display("test segmented packets done");
    stall <= 1;
    fork
      pkt(1, 2'h0, 5'h02, 1, 1, 11'h020, {16'h00ff, 5'h00, 11'h020});
      begin
        repeat (80) @(posedge aclk);
        stall <= 0;
      end
    join
    status(32'h2);
    $display("test receiver stall done");
    pkt(0, 2'h3, 5'h00, 1, 1, 11'h008, {16'h0001, 5'h00, 11'h008});
    status(32'h1);
    check("bytes left", 32'h0, expq.size());
    $display("test reserved alignment done");
    give_verdict();
  end
endmodule
